// >>> src/sbrs_map.vh
`ifndef SBRS_MAP_VH
`define SBRS_MAP_VH
// register offsets
`define SBRS_ADDR_CTRL     4'h0
`define SBRS_ADDR_STATUS   4'h1
// control register fields
`define SBRS_CTRL_OSC_SETTLE_TIME_SELECT_LSB 0
`define SBRS_CTRL_OSC_SETTLE_TIME_SELECT_MSB 2
`define SBRS_CTRL_NSCS_BIT 3
`define SBRS_CTRL_TMK0_BIT 4
`define SBRS_CTRL_TMK1_BIT 5
`define SBRS_CTRL_RESET    8'h30
// status register fields
`define SBRS_STAT_TF0_BIT  0
`define SBRS_STAT_TF1_BIT  1
`define SBRS_STAT_HALT_BIT 2
`define SBRS_STAT_STOP_BIT 3
`define SBRS_STAT_SETL_BIT 4
`define SBRS_STAT_RST_BIT  5
`define SBRS_STAT_RUN_BIT  6
// settling waits as powers of two of main-clock periods
`define SBRS_SETTLE_SEL0   13
`define SBRS_SETTLE_SEL1   15
`define SBRS_SETTLE_SEL2   16
`define SBRS_SETTLE_SEL3   17
`define SBRS_SETTLE_SEL4   18
`define SBRS_SETTLE_RESET  18
// reset vector byte addresses
`define SBRS_VEC_LO_ADDR   16'h0000
`define SBRS_VEC_HI_ADDR   16'h0001
`endif

// >>> src/sbrs_standby_reset_seq.v
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sbrs_map.vh"

module sbrs_standby_reset_seq #(
   parameter NIRQ            = 12,
   parameter [11:0] MAIN_SRC = 12'h000,
   parameter SHIFT0          = `SBRS_SETTLE_SEL0,
   parameter SHIFT1          = `SBRS_SETTLE_SEL1,
   parameter SHIFT2          = `SBRS_SETTLE_SEL2,
   parameter SHIFT3          = `SBRS_SETTLE_SEL3,
   parameter SHIFT4          = `SBRS_SETTLE_SEL4,
   parameter SHIFT_RST       = `SBRS_SETTLE_RESET
) (
   input  wire            clk,
   input  wire            rst,
   input  wire [3:0]      reg_addr,
   input  wire [7:0]      reg_wdata,
   input  wire            reg_wr,
   input  wire            reg_rd,
   output reg  [7:0]      reg_rdata_q,
   input  wire            halt_exec,
   input  wire            stop_exec,
   input  wire            cpu_on_subclock,
   input  wire [NIRQ-1:0] irq_req,
   input  wire [NIRQ-1:0] irq_mask,
   input  wire            nmi_req,
   input  wire            timer_overflow_test_input,
   input  wire            port_edge_test_input,
   input  wire            reset_pin_n,
   input  wire            watchdog_overflow_request,
   input  wire            wdt_reset_en,
   input  wire            supply_low,
   input  wire [7:0]      vec_data,
   output reg  [15:0]     vec_addr_q,
   output reg             pc_load_q,
   output reg  [15:0]     pc_value_q,
   output reg             cpu_clk_en_q,
   output reg             cpu_reset_q,
   output reg             main_osc_en_q,
   output reg             main_clock_input_gnd_q,
   output reg             main_periph_en_q,
   output reg             sub_osc_en_q
);

   localparam [7:0] S_RUN  = 8'h01;
   localparam [7:0] S_HALT = 8'h02;
   localparam [7:0] S_STOP = 8'h04;
   localparam [7:0] S_SETL = 8'h08;
   localparam [7:0] S_RST  = 8'h10;
   localparam [7:0] S_VLO  = 8'h20;
   localparam [7:0] S_VHI  = 8'h40;
   localparam [7:0] S_RSET = 8'h80;

   reg  [7:0]  state_q;
   reg  [7:0]  state_d;
   reg  [18:0] cnt_q;
   reg  [18:0] cnt_d;
   reg  [18:0] term;
   reg  [7:0]  ctrl_q;
   reg  [1:0]  tflag_q;
   reg  [1:0]  tflag_d;
   reg         pedge_s3_q;
   reg         cpu_clk_en_d;
   reg         cpu_reset_d;
   reg         main_osc_en_d;
   reg         main_clock_input_gnd_d;
   reg         main_periph_en_d;

   wire [2:0]      osc_settle_time_select_sel;
   wire            nscs;
   wire [1:0]      tmask;
   wire [NIRQ-1:0] irq_live;
   wire [NIRQ-1:0] irq_halt_ok;
   wire [NIRQ-1:0] irq_stop_ok;
   wire            test_wake;
   wire            wake_halt;
   wire            wake_stop;
   wire            reset_req;
   wire            pedge_fall;
   wire            stat_wr;
   wire            rpin_sync;
   wire            pedge_sync;
   wire [7:0]      status_word;

   assign osc_settle_time_select_sel = ctrl_q[`SBRS_CTRL_OSC_SETTLE_TIME_SELECT_MSB:`SBRS_CTRL_OSC_SETTLE_TIME_SELECT_LSB];
   assign nscs     = ctrl_q[`SBRS_CTRL_NSCS_BIT];
   assign tmask    = {ctrl_q[`SBRS_CTRL_TMK1_BIT], ctrl_q[`SBRS_CTRL_TMK0_BIT]};
   assign stat_wr  = reg_wr && (reg_addr == `SBRS_ADDR_STATUS);

   // wake qualification
   assign irq_live    = irq_req & ~irq_mask;
   assign irq_halt_ok = irq_live & {{(NIRQ-1){1'b1}}, nscs};
   assign irq_stop_ok = irq_live & ~MAIN_SRC & {{(NIRQ-1){1'b1}}, 1'b0};
   assign test_wake   = |(tflag_q & ~tmask);
   assign wake_halt   = |irq_halt_ok | nmi_req | test_wake;
   assign wake_stop   = (|irq_stop_ok | nmi_req | test_wake) & ~supply_low;
   assign reset_req   = ~rpin_sync | (watchdog_overflow_request & wdt_reset_en);
   assign pedge_fall  = pedge_s3_q & ~pedge_sync;

   // status word as software sees it
   assign status_word[`SBRS_STAT_TF1_BIT:`SBRS_STAT_TF0_BIT] = tflag_q;
   assign status_word[`SBRS_STAT_HALT_BIT] = (state_q == S_HALT);
   assign status_word[`SBRS_STAT_STOP_BIT] = (state_q == S_STOP);
   assign status_word[`SBRS_STAT_SETL_BIT] = (state_q == S_SETL) || (state_q == S_RSET);
   assign status_word[`SBRS_STAT_RST_BIT]  = cpu_reset_q;
   assign status_word[`SBRS_STAT_RUN_BIT]  = (state_q == S_RUN);
   assign status_word[7]                   = 1'b0;

   // pin synchronisers; the reset pin reads as low until two clean edges
   sbrs_sync2 #(
      .INIT (1'b0)
   ) u_sbrs_sync2_rpin (
      .clk    (clk),
      .rst    (rst),
      .din    (reset_pin_n),
      .dout_q (rpin_sync)
   );

   sbrs_sync2 #(
      .INIT (1'b1)
   ) u_sbrs_sync2_pedge (
      .clk    (clk),
      .rst    (rst),
      .din    (port_edge_test_input),
      .dout_q (pedge_sync)
   );

   // third stage for the falling-edge detector; idles high like the pin
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         pedge_s3_q <= 1'b1;
      else
         pedge_s3_q <= pedge_sync;
   end

   // test request flags: set wins over a software clear
   always @*
   begin
      tflag_d = tflag_q;
      if (stat_wr)
         tflag_d = tflag_q & ~reg_wdata[`SBRS_STAT_TF1_BIT:`SBRS_STAT_TF0_BIT];
      if (timer_overflow_test_input)
         tflag_d[0] = 1'b1;
      if (pedge_fall)
         tflag_d[1] = 1'b1;
   end

   // settling terminal count from the selected wait, or from the fixed reset wait in S_RSET
   always @*
   begin
      term = 19'h00000;
      if (state_q == S_RSET)
         term[SHIFT_RST] = 1'b1;
      else
      begin
         case (osc_settle_time_select_sel)
            3'h0: term[SHIFT0] = 1'b1;
            3'h1: term[SHIFT1] = 1'b1;
            3'h2: term[SHIFT2] = 1'b1;
            3'h3: term[SHIFT3] = 1'b1;
            default: term[SHIFT4] = 1'b1;
         endcase
      end
   end

   always @*
   begin
      state_d = state_q;
      cnt_d   = 19'h00000;
      if (reset_req)
         state_d = S_RST;
      else
      begin
         case (state_q)
            S_RUN:
            begin
               if (stop_exec && !cpu_on_subclock)
                  state_d = S_STOP;
               else if (halt_exec)
                  state_d = S_HALT;
            end
            S_HALT:
            begin
               if (wake_halt)
                  state_d = S_RUN;
            end
            S_STOP:
            begin
               if (wake_stop)
                  state_d = S_SETL;
            end
            S_SETL, S_RSET:
            begin
               cnt_d = cnt_q + 19'h00001;
               if (cnt_d == term)
                  state_d = S_RUN;
            end
            S_RST:
               state_d = S_VLO;
            S_VLO:
               state_d = S_VHI;
            S_VHI:
               state_d = S_RSET;
            default:
               state_d = S_RST;
         endcase
      end
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= S_RST;
         cnt_q   <= 19'h00000;
         ctrl_q  <= `SBRS_CTRL_RESET;
         tflag_q <= 2'b00;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         tflag_q <= tflag_d;
         if (reg_wr && (reg_addr == `SBRS_ADDR_CTRL))
            ctrl_q <= reg_wdata;
      end
   end

   // reset vector fetch: low byte then high byte
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         vec_addr_q <= `SBRS_VEC_LO_ADDR;
         pc_load_q  <= 1'b0;
         pc_value_q <= 16'h0000;
      end
      else
      begin
         pc_load_q <= 1'b0;
         if (state_d == S_VHI)
            vec_addr_q <= `SBRS_VEC_HI_ADDR;
         else
            vec_addr_q <= `SBRS_VEC_LO_ADDR;
         if (state_q == S_VLO)
            pc_value_q[7:0] <= vec_data;
         if (state_q == S_VHI)
         begin
            pc_value_q[15:8] <= vec_data;
            pc_load_q        <= 1'b1;
         end
      end
   end

   // next values of the clock and oscillator controls
   always @*
   begin
      cpu_clk_en_d           = (state_d == S_RUN);
      cpu_reset_d            = (state_d == S_RST) || (state_d == S_VLO) ||
                               (state_d == S_VHI) || (state_d == S_RSET);
      main_osc_en_d          = (state_d != S_STOP) && (state_d != S_RST);
      main_clock_input_gnd_d = (state_d == S_STOP);
      main_periph_en_d       = (state_d == S_RUN) || (state_d == S_HALT);
   end

   // clock gating and oscillator controls
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cpu_clk_en_q           <= 1'b0;
         cpu_reset_q            <= 1'b1;
         main_osc_en_q          <= 1'b0;
         main_clock_input_gnd_q <= 1'b1;
         main_periph_en_q       <= 1'b0;
         sub_osc_en_q           <= 1'b1;
      end
      else
      begin
         cpu_clk_en_q           <= cpu_clk_en_d;
         cpu_reset_q            <= cpu_reset_d;
         main_osc_en_q          <= main_osc_en_d;
         main_clock_input_gnd_q <= main_clock_input_gnd_d;
         main_periph_en_q       <= main_periph_en_d;
         sub_osc_en_q           <= 1'b1;
      end
   end

   // register read port, data one cycle after the strobe
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_rdata_q <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `SBRS_ADDR_CTRL:   reg_rdata_q <= ctrl_q;
            `SBRS_ADDR_STATUS: reg_rdata_q <= status_word;
            default:           reg_rdata_q <= 8'h00;
         endcase
      end
      else
         reg_rdata_q <= 8'h00;
   end

endmodule // sbrs_standby_reset_seq

module sbrs_sync2 #(
   parameter [0:0] INIT = 1'b0
) (
   input  wire clk,
   input  wire rst,
   input  wire din,
   output reg  dout_q
);

   reg meta_q;

   // only dout_q is read outside; meta_q may still be settling
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= INIT;
         dout_q <= INIT;
      end
      else
      begin
         meta_q <= din;
         dout_q <= meta_q;
      end
   end

endmodule // sbrs_sync2
`default_nettype wire

// >>> verification/sbrs_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbrs_cpu_model (
   input  wire logic [15:0] vec_addr_q,
   output logic      [7:0]  vec_data
);
   // vector bytes at 0 and 1; other addresses show the inverted low address byte
   always_comb
      vec_data = (vec_addr_q == 16'h0000) ? 8'h34 :
                 (vec_addr_q == 16'h0001) ? 8'h12 : ~vec_addr_q[7:0];
endmodule // sbrs_cpu_model
`default_nettype wire

// >>> verification/sbrs_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sbrs_chk #(
   parameter SHIFT_RST = 18
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic halt_exec,
   input wire logic stop_exec,
   input wire logic cpu_on_subclock,
   input wire logic watchdog_overflow_request,
   input wire logic wdt_reset_en,
   input wire logic pc_load_q,
   input wire logic cpu_clk_en_q,
   input wire logic cpu_reset_q,
   input wire logic main_osc_en_q,
   input wire logic main_clock_input_gnd_q,
   input wire logic main_periph_en_q,
   input wire logic sub_osc_en_q
);
   localparam int WLO = (1 << SHIFT_RST) - 9;
   localparam int WHI = (1 << SHIFT_RST) - 5;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_halt_gate: assert property (
      cpu_clk_en_q && halt_exec && !stop_exec |=> !cpu_clk_en_q && main_osc_en_q)
      else $error("halt gate");
   chk_stop_ground: assert property (
      cpu_clk_en_q && stop_exec && !cpu_on_subclock |=> main_clock_input_gnd_q)
      else $error("stop ground");
   chk_stop_subclk: assert property (
      cpu_clk_en_q && stop_exec && cpu_on_subclock && !halt_exec |=> cpu_clk_en_q)
      else $error("stop on subclock");
   chk_ground_idle: assert property (
      main_clock_input_gnd_q |-> !cpu_clk_en_q && !main_periph_en_q && sub_osc_en_q)
      else $error("ground idle");
   chk_settle_hold: assert property (
      $fell(main_clock_input_gnd_q) |-> (!cpu_clk_en_q)[*3])
      else $error("settle hold");
   chk_wdt_reset: assert property (
      watchdog_overflow_request && wdt_reset_en |-> ##[1:2]
      (cpu_reset_q && !main_osc_en_q && sub_osc_en_q))
      else $error("watchdog reset");
   chk_vec_pulse: assert property (
      pc_load_q |=> !pc_load_q && !cpu_clk_en_q)
      else $error("vector load pulse");
   chk_reset_wait: assert property (
      pc_load_q |-> (!cpu_clk_en_q)[*8] ##[WLO:WHI] $rose(cpu_clk_en_q))
      else $error("reset wait");
   cover property (halt_exec && cpu_clk_en_q);
   cover property ($fell(main_clock_input_gnd_q) && !cpu_reset_q);
   cover property (pc_load_q);
endmodule // sbrs_chk
bind sbrs_standby_reset_seq sbrs_chk #(.SHIFT_RST(SHIFT_RST)) u_sbrs_chk (.clk, .rst,
   .halt_exec, .stop_exec, .cpu_on_subclock, .watchdog_overflow_request, .wdt_reset_en,
   .pc_load_q, .cpu_clk_en_q, .cpu_reset_q, .main_osc_en_q, .main_clock_input_gnd_q,
   .main_periph_en_q, .sub_osc_en_q);
`default_nettype wire

// >>> verification/standby_reset_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module standby_reset_sequencer_test;
   logic        clk, rst, reg_wr, reg_rd, halt_exec, stop_exec, cpu_on_subclock, nmi_req;
   logic        timer_overflow_test_input, reset_pin_n, watchdog_overflow_request;
   logic        port_edge_test_input;
   logic        wdt_reset_en, supply_low, pc_load_q, cpu_clk_en_q, cpu_reset_q;
   logic        main_osc_en_q, main_clock_input_gnd_q, main_periph_en_q, sub_osc_en_q;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata_q, vec_data;
   logic [11:0] irq_req, irq_mask;
   logic [15:0] vec_addr_q, pc_value_q;
   int          errors, tests_run, n, sh;
   // selects 0 and 1 keep their full waits; the longer ones are shortened for run time
   sbrs_standby_reset_seq #(.MAIN_SRC(12'h002), .SHIFT2(4),
      .SHIFT3(5), .SHIFT4(6), .SHIFT_RST(6)) u_sbrs_standby_reset_seq (.clk, .rst,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .halt_exec, .stop_exec,
      .cpu_on_subclock, .irq_req, .irq_mask, .nmi_req, .timer_overflow_test_input,
      .port_edge_test_input, .reset_pin_n, .watchdog_overflow_request,
      .wdt_reset_en, .supply_low, .vec_data, .vec_addr_q, .pc_load_q, .pc_value_q,
      .cpu_clk_en_q, .cpu_reset_q, .main_osc_en_q, .main_clock_input_gnd_q,
      .main_periph_en_q, .sub_osc_en_q);
   sbrs_cpu_model u_sbrs_cpu_model (.vec_addr_q, .vec_data);
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task tick;
      @(posedge clk);
      #1;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      tick;
      reg_wr <= 1'b0;
      tick;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      tick;
      reg_rd <= 1'b0;
      chk(reg_rdata_q, e);
      tick;
   endtask
   task op(input logic s);
      stop_exec <= s;
      halt_exec <= !s;
      tick;
      {stop_exec, halt_exec} <= 2'b00;
      tick;
   endtask
   task wait_run;
      n = 0;
      while (cpu_clk_en_q !== 1'b1 && n < 40000)
      begin
         tick;
         n++;
      end
   endtask
   task t_boot;
      n = 0;
      while (pc_load_q !== 1'b1 && n < 50)
      begin
         tick;
         n++;
      end
      chk(pc_value_q, 16'h1234);
      wait_run;
      chk(16'(n > 61 && n < 67), 16'h1);
   endtask
   task t_halt;
      wr(4'h0, 8'h20);
      irq_mask <= 12'hffe;
      op(1'b0);
      chk(cpu_clk_en_q, 1'b0);
      chk(main_osc_en_q, 1'b1);
      rd(4'h1, 8'h04);
      irq_req <= 12'h001;
      repeat (4) tick;
      chk(cpu_clk_en_q, 1'b0);
      wr(4'h0, 8'h28);
      repeat (3) tick;
      chk(cpu_clk_en_q, 1'b1);
      irq_req <= 12'h000;
      tick;
      op(1'b0);
      timer_overflow_test_input <= 1'b1;
      tick;
      timer_overflow_test_input <= 1'b0;
      repeat (3) tick;
      chk(cpu_clk_en_q, 1'b1);
      rd(4'h1, 8'h41);
      wr(4'h1, 8'h01);
      rd(4'h1, 8'h40);
      wr(4'h0, 8'h18);
      op(1'b0);
      port_edge_test_input <= 1'b0;
      repeat (6) tick;
      chk(cpu_clk_en_q, 1'b1);
      rd(4'h1, 8'h42);
      port_edge_test_input <= 1'b1;
      wr(4'h1, 8'h02);
      rd(4'h1, 8'h40);
   endtask
   task t_stop;
      for (int s = 0; s < 6; s++)
      begin
         wr(4'h0, 8'(8'h30 + s));
         irq_mask <= 12'hffc;
         op(1'b1);
         chk(main_clock_input_gnd_q, 1'b1);
         chk(main_periph_en_q, 1'b0);
         irq_req <= 12'h003;
         repeat (4) tick;
         chk(main_clock_input_gnd_q, 1'b1);
         {supply_low, nmi_req} <= 2'b11;
         repeat (4) tick;
         chk(main_clock_input_gnd_q, 1'b1);
         supply_low <= 1'b0;
         wait_run;
         sh = (s == 0) ? 13 : (s == 1) ? 15 : (s < 5) ? s + 2 : 6;
         chk(16'(n >= (1 << sh) && n <= (1 << sh) + 2), 16'h1);
         {irq_req, nmi_req} <= '0;
         tick;
      end
   endtask
   task t_reset;
      cpu_on_subclock <= 1'b1;
      op(1'b1);
      chk(cpu_clk_en_q, 1'b1);
      cpu_on_subclock <= 1'b0;
      watchdog_overflow_request <= 1'b1;
      repeat (3) tick;
      chk(cpu_clk_en_q, 1'b1);
      wdt_reset_en <= 1'b1;
      tick;
      {watchdog_overflow_request, wdt_reset_en} <= 2'b00;
      tick;
      chk(cpu_reset_q, 1'b1);
      t_boot;
      op(1'b0);
      reset_pin_n <= 1'b0;
      repeat (5) tick;
      chk(cpu_reset_q, 1'b1);
      chk(main_osc_en_q, 1'b0);
      chk(sub_osc_en_q, 1'b1);
      reset_pin_n <= 1'b1;
      t_boot;
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #400000;
      errors++;
      test_done;
   end
   initial
   begin
      rst = 1'b1;
      {reg_wr, reg_rd, halt_exec, stop_exec, cpu_on_subclock, nmi_req} = '0;
      {timer_overflow_test_input, watchdog_overflow_request, wdt_reset_en} = '0;
      {supply_low, reg_addr, reg_wdata, irq_req} = '0;
      irq_mask = '1;
      reset_pin_n = 1'b1;
      port_edge_test_input = 1'b1;
      errors = 0;
      tests_run = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_boot;
      rd(4'h0, 8'h30);
      rd(4'h1, 8'h40);
      rd(4'h7, 8'h00);
      t_halt;
      t_stop;
      t_reset;
      test_done;
   end
endmodule // standby_reset_sequencer_test
`default_nettype wire
